// ==== verilog/fesc_map.svh ====
`ifndef FESC_MAP_SVH
`define FESC_MAP_SVH

// ---------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ---------------------------------------------------------------------------
`define FESC_OFS_MODE    8'h00
`define FESC_OFS_SETUP   8'h04
`define FESC_OFS_BLOCK   8'h08
`define FESC_OFS_WAIT    8'h0C

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define FESC_FLASH_WE_BIT     7
`define FESC_SOFT_WE_BIT      6
`define FESC_ERASE_VFY_BIT    3
`define FESC_PROG_VFY_BIT     2
`define FESC_E_BIT            1
`define FESC_P_BIT            0
`define FESC_ERR_FLAG_BIT     7
`define FESC_ERASE_SETUP_BIT  1
`define FESC_PROG_SETUP_BIT   0
`define FESC_CLK_DIV_BIT      5
`define FESC_REG_EN_BIT       4

// ---------------------------------------------------------------------------
// Reset values and bus responses
// ---------------------------------------------------------------------------
`define FESC_SETUP_RST   8'h00
`define FESC_BLOCK_RST   8'h00
`define FESC_WAIT_RST    8'h08
`define FESC_RESP_OKAY   2'h0
`define FESC_RESP_SLVERR 2'h2

// ---------------------------------------------------------------------------
// Erase block upper bounds, exclusive
// ---------------------------------------------------------------------------
`define FESC_BLK0_END    16'h0400
`define FESC_BLK1_END    16'h0800
`define FESC_BLK2_END    16'h0C00
`define FESC_BLK3_END    16'h1000
`define FESC_BLK4_END    16'h8000
`define FESC_BLK5_END    16'hC000
`define FESC_BLK6_END    16'hEF80
`define FESC_BLK7_END    16'hF780

`endif

// ==== verilog/fesc_pkg.sv ====
`default_nettype none

package fesc_pkg;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    FESC_SEL_MODE,
    FESC_SEL_SETUP,
    FESC_SEL_BLOCK,
    FESC_SEL_WAIT,
    FESC_SEL_NONE
  } fesc_sel_t;

  typedef logic [7:0] fesc_byte_t;

endpackage

`default_nettype wire

// ==== verilog/fesc_mode_reg.sv ====
`default_nettype none
`include "fesc_map.svh"

module fesc_mode_reg
  import fesc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       clear,
  input  wire logic       wr_en,
  input  wire fesc_byte_t wdata,
  input  wire logic       flash_we_in,
  input  wire logic       erase_setup,
  input  wire logic       program_setup,
  input  wire logic       error_protect,
  output fesc_byte_t      value,
  output logic            soft_we
);

  logic erase_vfy;
  logic prog_vfy;
  logic e;
  logic p;

  // ---------------------------------------------------------------------------
  // Mode bits with their setting conditions
  // ---------------------------------------------------------------------------
  // Gates use the value before the write, so a write that raises the enable
  // cannot also raise a bit that depends on it.
  always_ff @(posedge aclk) begin
    if (clear) begin
      soft_we   <= 1'b0;
      erase_vfy <= 1'b0;
      prog_vfy  <= 1'b0;
      e         <= 1'b0;
      p         <= 1'b0;
    end else if (wr_en) begin
      soft_we   <= wdata[`FESC_SOFT_WE_BIT];
      erase_vfy <= wdata[`FESC_ERASE_VFY_BIT] & soft_we;
      prog_vfy  <= wdata[`FESC_PROG_VFY_BIT] & soft_we;
      e <= wdata[`FESC_E_BIT] & flash_we_in & soft_we & erase_setup & ~error_protect;
      p <= wdata[`FESC_P_BIT] & soft_we & program_setup & ~error_protect;
    end else if (error_protect) begin
      e   <= 1'b0;
      p   <= 1'b0;
    end
  end

  // Bits 5 and 4 read as zero; the write enable bit follows its pin.
  assign value = {flash_we_in, soft_we, 2'b00, erase_vfy, prog_vfy, e, p};

endmodule

`default_nettype wire

// ==== verilog/fesc_block_map.sv ====
`default_nettype none
`include "fesc_map.svh"

module fesc_block_map
  import fesc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire fesc_byte_t  block_select,
  input  wire logic [15:0] erase_addr,
  output logic             erase_allowed
);

  // Returns the one-hot block of an address, zero above the last block.
  function automatic fesc_byte_t block_of(input logic [15:0] a);
    fesc_byte_t r;
    r = 8'h00;
    if (a < `FESC_BLK0_END)      r = 8'h01;
    else if (a < `FESC_BLK1_END) r = 8'h02;
    else if (a < `FESC_BLK2_END) r = 8'h04;
    else if (a < `FESC_BLK3_END) r = 8'h08;
    else if (a < `FESC_BLK4_END) r = 8'h10;
    else if (a < `FESC_BLK5_END) r = 8'h20;
    else if (a < `FESC_BLK6_END) r = 8'h40;
    else if (a < `FESC_BLK7_END) r = 8'h80;
    return r;
  endfunction

  wire fesc_byte_t addr_block = block_of(erase_addr);

  // ---------------------------------------------------------------------------
  // Erase permission, registered so the sequencer sees a clean level
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_allowed <= 1'b0;
    end else begin
      erase_allowed <= |(addr_block & block_select);
    end
  end

endmodule

`default_nettype wire

// ==== verilog/fesc_top.sv ====
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
`include "fesc_map.svh"

module fesc_top
  import fesc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Operating mode levels from the system controller.
  input  wire logic              hw_standby,
  input  wire logic              sw_standby,
  input  wire logic              hw_protect,
  input  wire logic              sw_protect,
  input  wire logic              low_power,
  input  wire logic              flash_disabled,
  input  wire logic              flash_write_enable,
  // Flash array sequencer.
  input  wire logic              seq_error,
  input  wire logic [15:0]       erase_addr,
  output logic                   erase_setup,
  output logic                   program_setup,
  output logic                   error_protect,
  output fesc_byte_t             erase_block_select,
  output logic                   erase_allowed,
  output logic                   soft_write_enable,
  output logic                   erase_mode,
  output logic                   program_mode,
  output logic                   erase_verify_mode,
  output logic                   program_verify_mode,
  // Clock and wait-state controller.
  output logic                   periph_clock_div,
  output logic                   flash_reg_enable,
  output logic [1:0]             wait_mode_sel,
  output logic [1:0]             wait_count
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  fesc_byte_t        w_byte;
  logic              w_lane0;
  fesc_byte_t        block_sel;
  fesc_byte_t        wait_clock_ctrl;
  fesc_byte_t        mode_value;
  logic              soft_we;
  logic              flash_error_flag;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // The printed map is sparse, so anything off the four words is refused.
  function automatic fesc_sel_t decode(input logic [ADDR_W-1:0] a);
    fesc_sel_t s;
    case (a)
      ADDR_W'(`FESC_OFS_MODE):  s = FESC_SEL_MODE;
      ADDR_W'(`FESC_OFS_SETUP): s = FESC_SEL_SETUP;
      ADDR_W'(`FESC_OFS_BLOCK): s = FESC_SEL_BLOCK;
      ADDR_W'(`FESC_OFS_WAIT):  s = FESC_SEL_WAIT;
      default:                  s = FESC_SEL_NONE;
    endcase
    return s;
  endfunction

  // Flash control registers are visible only with the register enable set.
  function automatic logic is_flash_reg(input fesc_sel_t s);
    return (s == FESC_SEL_MODE) || (s == FESC_SEL_SETUP) || (s == FESC_SEL_BLOCK);
  endfunction

  wire fesc_sel_t wr_sel      = decode(aw_addr);
  wire fesc_sel_t rd_sel      = decode(s_axi_araddr);
  wire logic      wr_fire     = aw_held & w_held;
  wire logic      wr_gate     = is_flash_reg(wr_sel) ? flash_reg_enable : 1'b1;
  wire logic      wr_commit   = wr_fire & w_lane0 & wr_gate;
  wire logic      wr_mode     = wr_commit & (wr_sel == FESC_SEL_MODE) & ~flash_disabled;
  wire logic      wr_setup    = wr_commit & (wr_sel == FESC_SEL_SETUP);
  wire logic      wr_block    = wr_commit & (wr_sel == FESC_SEL_BLOCK);
  wire logic      wr_wait     = wr_commit & (wr_sel == FESC_SEL_WAIT);
  wire logic      rd_fire     = s_axi_arvalid & s_axi_arready;
  wire logic      rd_visible  = is_flash_reg(rd_sel) ? flash_reg_enable : 1'b1;

  // Mode-driven clears grouped once so every register uses the same terms.
  wire logic      hard_clear  = ~aresetn | hw_standby;
  wire logic      mode_clear  = hard_clear | sw_standby;
  wire logic      setup_clear = sw_standby | hw_protect | sw_protect;

  // ---------------------------------------------------------------------------
  // Write channel handshakes
  // ---------------------------------------------------------------------------
  // Address and data are accepted in either order and held until both are in;
  // nothing new is taken while a response waits, so one write is in flight.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Address side of a write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Data side of a write; only byte lane 0 carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held  <= 1'b0;
    end
  end

  // Write response, raised on the edge that commits the write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FESC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == FESC_SEL_NONE) ? `FESC_RESP_SLVERR : `FESC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Flash mode control register
  // ---------------------------------------------------------------------------
  fesc_mode_reg u_mode (
    .aclk          (aclk),
    .clear         (mode_clear),
    .wr_en         (wr_mode),
    .wdata         (w_byte),
    .flash_we_in   (flash_write_enable),
    .erase_setup   (erase_setup),
    .program_setup (program_setup),
    .error_protect (flash_error_flag),
    .value         (mode_value),
    .soft_we       (soft_we)
  );

  // ---------------------------------------------------------------------------
  // Program/erase setup and error register
  // ---------------------------------------------------------------------------
  // Setup bits are only raised under the software write enable; clearing
  // writes always land so software can back out of a half-built sequence.
  always_ff @(posedge aclk) begin
    if (hard_clear) begin
      erase_setup   <= 1'b0;
      program_setup <= 1'b0;
    end else if (setup_clear) begin
      erase_setup   <= 1'b0;
      program_setup <= 1'b0;
    end else if (wr_setup) begin
      erase_setup   <= w_byte[`FESC_ERASE_SETUP_BIT] & soft_we;
      program_setup <= w_byte[`FESC_PROG_SETUP_BIT] & soft_we;
    end
  end

  // Error flag: a sequencer error in the same cycle as a low-power clear
  // still sets it; in that cycle only reset or hardware standby drops the fault.
  always_ff @(posedge aclk) begin
    if (hard_clear) begin
      flash_error_flag <= 1'b0;
    end else if (seq_error) begin
      flash_error_flag <= 1'b1;
    end else if (low_power) begin
      flash_error_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Erase block selector
  // ---------------------------------------------------------------------------
  // Held at zero without the write enable, so a stale selection can never
  // survive into a later erase.
  always_ff @(posedge aclk) begin
    if (mode_clear || !soft_we) begin
      block_sel <= `FESC_BLOCK_RST;
    end else if (wr_block && !flash_disabled) begin
      block_sel <= w_byte;
    end
  end

  fesc_block_map u_map (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .block_select  (block_sel),
    .erase_addr    (erase_addr),
    .erase_allowed (erase_allowed)
  );

  // ---------------------------------------------------------------------------
  // Wait-state and clock control register
  // ---------------------------------------------------------------------------
  // Software standby leaves this register alone on purpose: clock and wait
  // settings must be intact when the core wakes.
  always_ff @(posedge aclk) begin
    if (hard_clear) begin
      wait_clock_ctrl <= `FESC_WAIT_RST;
    end else if (wr_wait) begin
      wait_clock_ctrl <= w_byte;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Read values per register; flash registers collapse to zero when the
  // flash is disabled or its registers are unselected.
  wire fesc_byte_t setup_value = {flash_error_flag, 5'b00000,
                                  erase_setup, program_setup};
  wire fesc_byte_t mode_rd     = flash_disabled ? 8'h00 : mode_value;
  wire fesc_byte_t setup_rd    = flash_disabled ? 8'h00 : setup_value;
  wire fesc_byte_t block_rd    = flash_disabled ? 8'h00 : block_sel;

  fesc_byte_t rd_byte;

  // Read multiplexer.
  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      FESC_SEL_MODE:  rd_byte = mode_rd;
      FESC_SEL_SETUP: rd_byte = setup_rd;
      FESC_SEL_BLOCK: rd_byte = block_rd;
      FESC_SEL_WAIT:  rd_byte = wait_clock_ctrl;
      default:        rd_byte = 8'h00;
    endcase
  end

  // Read data is captured at the address handshake and held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FESC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_visible ? rd_byte : 8'h00};
      s_axi_rresp  <= (rd_sel == FESC_SEL_NONE) ? `FESC_RESP_SLVERR : `FESC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs to the sequencer and clock logic
  // ---------------------------------------------------------------------------
  assign error_protect       = flash_error_flag;
  assign erase_block_select  = block_sel;
  assign soft_write_enable   = soft_we;
  assign erase_verify_mode   = mode_value[`FESC_ERASE_VFY_BIT];
  assign program_verify_mode = mode_value[`FESC_PROG_VFY_BIT];
  assign erase_mode          = mode_value[`FESC_E_BIT];
  assign program_mode        = mode_value[`FESC_P_BIT];
  assign periph_clock_div    = wait_clock_ctrl[`FESC_CLK_DIV_BIT];
  assign flash_reg_enable    = wait_clock_ctrl[`FESC_REG_EN_BIT];
  assign wait_mode_sel       = wait_clock_ctrl[3:2];
  assign wait_count          = wait_clock_ctrl[1:0];

  // Protection bits are ignored by this slave; every access is treated alike.
  wire logic unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8],
                             s_axi_wstrb[3:1]};

endmodule

`default_nettype wire

// ==== verif/fesc_top_asserts.sv ====
`default_nettype none

module fesc_top_checker
  import fesc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              hw_standby,
  input wire logic              sw_standby,
  input wire logic              hw_protect,
  input wire logic              sw_protect,
  input wire logic              low_power,
  input wire logic              flash_disabled,
  input wire logic              flash_write_enable,
  input wire logic              seq_error,
  input wire logic [15:0]       erase_addr,
  input wire logic              erase_setup,
  input wire logic              program_setup,
  input wire logic              error_protect,
  input wire fesc_byte_t        erase_block_select,
  input wire logic              erase_allowed,
  input wire logic              soft_write_enable,
  input wire logic              erase_mode
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------
  // Expected erase window
  // ------
  // One-hot owner of an address; above the last block nothing may be erased.
  function automatic fesc_byte_t blk_of(input logic [15:0] a);
    if (a < 16'h1000) return 8'h01 << a[11:10];
    if (a < 16'h8000) return 8'h10;
    if (a < 16'hC000) return 8'h20;
    if (a < 16'hEF80) return 8'h40;
    return (a < 16'hF780) ? 8'h80 : 8'h00;
  endfunction

  // Combinational hit, compared one cycle later because the output is registered.
  logic hit;
  assign hit = |(blk_of(erase_addr) & erase_block_select);

  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------
  // Properties
  // ------
  hw_clear_a: assert property (
    hw_standby |=> !erase_setup && !program_setup && !error_protect && erase_block_select == 8'h00)
    else $error("state kept through hardware standby");
  prot_clear_a: assert property (
    (sw_standby || hw_protect || sw_protect) |=> !erase_setup && !program_setup)
    else $error("setup bit kept through standby or protect");
  err_set_a: assert property (
    seq_error && !hw_standby |=> error_protect)
    else $error("sequencer error did not raise protection");
  err_clr_a: assert property (
    low_power && !seq_error |=> !error_protect)
    else $error("low power did not clear the error flag");
  setup_gate_a: assert property (
    $rose(erase_setup) || $rose(program_setup) |-> $past(soft_write_enable))
    else $error("setup bit rose without write enable");
  blk_hold_a: assert property (
    !soft_write_enable |=> erase_block_select == 8'h00)
    else $error("selector nonzero without write enable");
  erase_map_a: assert property (
    1'b1 |=> erase_allowed == $past(hit))
    else $error("erase permission does not match the selector");
  dis_read_a: assert property (
    s_axi_arvalid && s_axi_arready && flash_disabled && s_axi_araddr[3:0] != 4'hC
    |=> s_axi_rdata == 32'h0000_0000)
    else $error("flash register read nonzero while disabled");
  mode_gate_a: assert property (
    $rose(erase_mode) |-> $past(erase_setup) && $past(soft_write_enable) && $past(flash_write_enable))
    else $error("erase mode entered without its conditions");
endmodule

bind fesc_top fesc_top_checker #(.ADDR_W(ADDR_W)) chk (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .hw_standby, .sw_standby, .hw_protect, .sw_protect, .low_power, .flash_disabled,
  .flash_write_enable, .seq_error, .erase_addr, .erase_setup, .program_setup,
  .error_protect, .erase_block_select, .erase_allowed, .soft_write_enable, .erase_mode
);

`default_nettype wire

// ==== verif/test_flash_erase_setup_control_regs.sv ====
`default_nettype none
`include "fesc_map.svh"

module test_flash_erase_setup_control_regs
  import fesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ------
  // Signals
  // ------
  localparam logic [7:0] MODE_A = `FESC_OFS_MODE;
  localparam logic [7:0] SET_A  = `FESC_OFS_SETUP;
  localparam logic [7:0] BLK_A  = `FESC_OFS_BLOCK;
  localparam logic [7:0] WAIT_A = `FESC_OFS_WAIT;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, fdis, wr_en_fl;
  logic        awready, wready, bvalid, arready, rvalid, allow, clk_div, reg_en;
  logic        setup_e, setup_p, err_prot, wr_en_sw, mode_e, mode_p, vfy_e, vfy_p;
  logic [1:0]  bresp, rresp, wms, wcnt;
  logic [3:0]  wstrb;
  logic [5:0]  md;
  logic [7:0]  awaddr, araddr, wdat;
  logic [15:0] eaddr;
  logic [31:0] rdata;
  fesc_byte_t  blk;
  int          num_errors, checks;
  logic [15:0] lo [8] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h8000,
                          16'hC000, 16'hEF80};
  logic [15:0] hi [8] = '{16'h03FF, 16'h07FF, 16'h0BFF, 16'h0FFF, 16'h7FFF, 16'hBFFF,
                          16'hEF7F, 16'hF77F};
  fesc_byte_t  wv [2] = '{8'hE7, 8'hDB};

  // Standby, protect, low-power and sequencer-error levels share one vector so a single task can pulse any of them.
  fesc_top uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata({24'h00_0000, wdat}),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .hw_standby(md[0]), .sw_standby(md[1]), .hw_protect(md[2]), .sw_protect(md[3]),
    .low_power(md[4]), .seq_error(md[5]), .flash_disabled(fdis), .flash_write_enable(wr_en_fl),
    .erase_addr(eaddr), .erase_setup(setup_e), .program_setup(setup_p),
    .error_protect(err_prot), .erase_block_select(blk), .erase_allowed(allow),
    .soft_write_enable(wr_en_sw), .erase_mode(mode_e), .program_mode(mode_p),
    .erase_verify_mode(vfy_e), .program_verify_mode(vfy_p), .periph_clock_div(clk_div),
    .flash_reg_enable(reg_en), .wait_mode_sel(wms), .wait_count(wcnt)
  );

  // Clock of 100 MHz.
  always #5 aclk = ~aclk;

  // ------
  // Tasks
  // ------
  // Ends the run; the only place that prints the verdict.
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready and valid are sampled before this edge's updates land, so no race.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    awaddr <= a;
    wdat <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 40) num_errors++;
    if (n == 40) give_verdict();
    check(bresp, (a > WAIT_A) ? `FESC_RESP_SLVERR : `FESC_RESP_OKAY);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 40) num_errors++;
    if (n == 40) give_verdict();
    check(rresp, (a > WAIT_A) ? `FESC_RESP_SLVERR : `FESC_RESP_OKAY);
    check(rdata, {24'h00_0000, exp});
  endtask

  task automatic pulse(input int k);
    md[k] <= 1'b1;
    @(posedge aclk);
    md[k] <= 1'b0;
    @(posedge aclk);
  endtask

  // Permission is registered, so it is read two edges after the address moves.
  task automatic ea(input logic [15:0] a, input logic e);
    eaddr <= a;
    repeat (2) @(posedge aclk);
    check(allow, e);
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, fdis, md} = '0;
    {awaddr, araddr, wdat, eaddr} = '0;
    wstrb = 4'hF;
    wr_en_fl = 1'b1;
    num_errors = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(WAIT_A, 8'h08);
    wr(MODE_A, 8'h40);
    check(wr_en_sw, 1'b0);
    foreach (wv[i]) begin
      wr(WAIT_A, wv[i]);
      rdc(WAIT_A, wv[i]);
      check({clk_div, reg_en, wms, wcnt}, wv[i][5:0]);
    end
    wr(SET_A, 8'h03);
    wr(BLK_A, 8'h01);
    rdc(SET_A, 8'h00);
    rdc(BLK_A, 8'h00);
    wr(MODE_A, 8'h40);
    wr(SET_A, 8'hFE);
    rdc(SET_A, 8'h02);
    wr_en_fl <= 1'b0;
    wr(MODE_A, 8'h42);
    rdc(MODE_A, 8'h40);
    wr_en_fl <= 1'b1;
    wr(MODE_A, 8'h42);
    check({setup_e, mode_e}, 2'b11);
    for (int i = 0; i < 8; i++) begin
      wr(BLK_A, 8'h01 << i);
      check(blk, 8'h01 << i);
      rdc(BLK_A, 8'h01 << i);
      ea(lo[i], 1'b1);
      ea(hi[i], 1'b1);
      ea(lo[(i + 1) % 8], 1'b0);
    end
    ea(16'hF780, 1'b0);
    pulse(1);
    rdc(SET_A, 8'h00);
    rdc(BLK_A, 8'h00);
    rdc(WAIT_A, 8'hDB);
    for (int k = 2; k < 4; k++) begin
      wr(MODE_A, 8'h40);
      wr(SET_A, 8'h02);
      pulse(k);
      rdc(SET_A, 8'h00);
    end
    wr(MODE_A, 8'h4C);
    check({vfy_e, vfy_p}, 2'b11);
    rdc(MODE_A, 8'hCC);
    wr(SET_A, 8'h01);
    pulse(5);
    rdc(SET_A, 8'h81);
    wr(MODE_A, 8'h41);
    check({err_prot, mode_p}, 2'b10);
    pulse(4);
    rdc(SET_A, 8'h01);
    wr(MODE_A, 8'h41);
    check(mode_p, 1'b1);
    pulse(5);
    rdc(MODE_A, 8'hC0);
    pulse(0);
    check({err_prot, setup_e, setup_p, wr_en_sw}, 4'h0);
    rdc(WAIT_A, 8'h08);
    wr(WAIT_A, 8'h10);
    wr(MODE_A, 8'h40);
    wr(SET_A, 8'h01);
    wr(BLK_A, 8'h02);
    fdis <= 1'b1;
    rdc(SET_A, 8'h00);
    rdc(BLK_A, 8'h00);
    wr(BLK_A, 8'h04);
    fdis <= 1'b0;
    rdc(BLK_A, 8'h02);
    wr(MODE_A, 8'h00);
    rdc(BLK_A, 8'h00);
    wr(8'h10, 8'h55);
    rdc(8'h10, 8'h00);
    wstrb <= 4'h0;
    wr(WAIT_A, 8'hFF);
    wstrb <= 4'hF;
    rdc(WAIT_A, 8'h10);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(WAIT_A, 8'h08);
    give_verdict();
  end
endmodule

`default_nettype wire
